// ===== rtl/hbs_sequencer.sv
// Purpose: Boot and operating stage sequencer of a USB hub controller
// Assumes: Pins synchronous to i_clk; i_rst_b is the chip reset
// Notes: Stage flow, strap decode and a host register slave
`timescale 1ns/1ns
`default_nettype none
module hbs_sequencer (
  input wire logic i_clk,
  input wire logic i_rst_b,
  // AXI4-Lite slave (the host configuration path)
  input wire logic [9:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [9:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Pins and status
  input wire logic i_reference_clock_in,
  input wire logic i_pll_locked,
  input wire logic [1:0] i_cfg_sel,
  input wire logic i_sda_in,
  input wire logic i_scl_in,
  input wire logic i_vbus,
  input wire logic i_usb_suspend,
  input wire logic i_eeprom_done,
  input wire logic i_chg_done,
  input wire logic [2:0] i_config_default,
  input wire logic [2:0] i_config_otp,
  output logic o_bus_probe_oe_b,
  output logic o_strap_oe_b,
  output logic o_reg12_en,
  output logic o_pll_en,
  output logic o_core_rst_b,
  output logic o_eeprom_load,
  output logic o_chg_start,
  output logic o_hub_connect,
  output logic o_normal,
  output logic o_self_powered,
  output logic o_straps_used,
  output logic o_smbus_en,
  output logic [2:0] o_config,
  output logic o_ec_en,
  output logic o_special_resume,
  output logic o_hub_reset
);
  import hbs_pkg::*;

  // Every register of the block lives in this one struct
  typedef struct packed {
    hbs_state_t state;
    logic [7:0] cnt;
    logic [2:0] method;
    logic [2:0] ctrl;
    logic [2:0] host_cfg;
    logic [2:0] cfg_mask;
    logic [2:0] merged;
    logic susp_keep;
    logic ec_en;
    logic sres_en;
    logic hub_rst;
    logic chg_go;
    logic eep_go;
    logic probe;
    logic aw_got;
    logic w_got;
    logic [9:0] aw;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } hbs_regs_t;

  hbs_regs_t r_reg;
  hbs_regs_t r_next;
  logic smbus_ok;
  logic wr_fire;
  logic bus_seen;

  // SMBus answers only once digital logic is stable, and in suspend only while susp_keep is set
  always_comb begin
    smbus_ok = 1'b1;
    if (r_reg.state == HBS_ST_STANDBY || r_reg.state == HBS_ST_HARD_INIT) begin
      smbus_ok = 1'b0;
    end
    if (i_usb_suspend && !r_reg.susp_keep) begin
      smbus_ok = 1'b0;
    end
  end

  // External pull-ups overpower the weak probe pull-downs on both lines
  assign bus_seen = r_reg.probe && i_sda_in && i_scl_in;
  // A write commits once both halves are held and the last answer is gone
  assign wr_fire = r_reg.aw_got && r_reg.w_got && !r_reg.bvalid;

  always_comb begin
    r_next = r_reg;
    // One-cycle pulses fall back unless re-armed below
    r_next.chg_go = 1'b0;
    r_next.eep_go = 1'b0;
    r_next.hub_rst = 1'b0;
    // Address and data are taken independently, held until the response
    if (i_awvalid && !r_reg.aw_got) begin
      r_next.aw_got = 1'b1;
      r_next.aw = i_awaddr;
    end
    if (i_wvalid && !r_reg.w_got) begin
      r_next.w_got = 1'b1;
      r_next.wd = i_wdata;
      r_next.ws = i_wstrb;
    end
    if (r_reg.bvalid && i_bready) begin
      r_next.bvalid = 1'b0;
    end
    if (r_reg.rvalid && i_rready) begin
      r_next.rvalid = 1'b0;
    end
    if (wr_fire) begin
      r_next.aw_got = 1'b0;
      r_next.w_got = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = HBS_RESP_OKAY;
      if (!smbus_ok) begin
        r_next.bresp = HBS_RESP_SLVERR;
      end else if (r_reg.ws[0]) begin
        case (r_reg.aw)
          HBS_ADDR_CTRL: begin
            r_next.ctrl = r_reg.wd[2:0];
          end
          HBS_ADDR_SUSP: begin
            r_next.susp_keep = r_reg.wd[0];
          end
          HBS_ADDR_VCMD: begin
            // Vendor commands gated by an enable that defaults on
            if (r_reg.ctrl[HBS_CTRL_VCMD_EN]) begin
              case (r_reg.wd[2:0])
                HBS_VCMD_EC_ON: r_next.ec_en = 1'b1;
                HBS_VCMD_EC_OFF: r_next.ec_en = 1'b0;
                HBS_VCMD_SR_ON: r_next.sres_en = 1'b1;
                HBS_VCMD_SR_OFF: r_next.sres_en = 1'b0;
                HBS_VCMD_RESET: r_next.hub_rst = 1'b1;
                default: r_next.bresp = HBS_RESP_SLVERR;
              endcase
            end
          end
          HBS_ADDR_DONE: begin
            // Host settings ride with the completion write
            r_next.host_cfg = r_reg.wd[2:0];
            r_next.cfg_mask = r_reg.wd[10:8];
            if (r_reg.state == HBS_ST_SOC_CFG) begin
              r_next.state = HBS_ST_CONFIG;
            end
          end
          default: begin
            if (r_reg.aw != HBS_ADDR_STAT) begin
              r_next.bresp = HBS_RESP_SLVERR;
            end
          end
        endcase
      end
    end
    // Reads
    // A read answers one cycle after it is taken; arready stays low meanwhile
    if (i_arvalid && !r_reg.rvalid) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = HBS_RESP_OKAY;
      r_next.rdata = 32'h0;
      if (!smbus_ok) begin
        r_next.rresp = HBS_RESP_SLVERR;
      end else begin
        case (i_araddr)
          HBS_ADDR_CTRL: r_next.rdata = {29'h0, r_reg.ctrl};
          HBS_ADDR_STAT: r_next.rdata = {13'h0, r_reg.merged, 3'h0, r_reg.method,
                                         r_reg.state};
          HBS_ADDR_SUSP: r_next.rdata = {31'h0, r_reg.susp_keep};
          HBS_ADDR_VCMD: r_next.rdata = {30'h0, r_reg.sres_en, r_reg.ec_en};
          default: r_next.rresp = HBS_RESP_SLVERR;
        endcase
      end
    end
    // Stage sequencing
    case (r_reg.state)
      HBS_ST_STANDBY: begin
        // Regulator and PLL come up as soon as reset lets go
        r_next.state = HBS_ST_HARD_INIT;
        r_next.cnt = 8'h0;
      end
      HBS_ST_HARD_INIT: begin
        // The settle count saturates, so a missing reference clock just parks here
        if (r_reg.cnt < HBS_HARD_INIT_CYC) begin
          r_next.cnt = r_reg.cnt + 8'h1;
        end
        if (r_reg.cnt == 8'h1) begin
          // Straps settled while undriven; latch once, after release
          case ({i_sda_in, i_cfg_sel})
            3'h0, 3'h4: r_next.method = HBS_CFG_SELF;
            3'h2, 3'h6: r_next.method = HBS_CFG_BUS;
            3'h7: r_next.method = HBS_CFG_EEPROM;
            3'h5: r_next.method = HBS_CFG_SMBUS;
            default: r_next.method = HBS_CFG_INVALID;
          endcase
        end
        if (r_reg.cnt >= HBS_HARD_INIT_CYC && i_reference_clock_in && i_pll_locked) begin
          r_next.state = HBS_ST_FW_INIT;
        end
      end
      HBS_ST_FW_INIT: begin
        case (r_reg.method)
          HBS_CFG_EEPROM: begin
            r_next.state = HBS_ST_CONFIG;
            r_next.eep_go = 1'b1;
          end
          HBS_CFG_INVALID: r_next.state = HBS_ST_HALT;
          default: begin
            // Weak pull-downs for one cycle; strong host pull-ups still read high
            r_next.probe = 1'b1;
            if (bus_seen) begin
              r_next.state = HBS_ST_SOC_CFG;
              r_next.probe = 1'b0;
            end else if (r_reg.probe) begin
              r_next.state = HBS_ST_CONFIG;
              r_next.probe = 1'b0;
            end
          end
        endcase
      end
      HBS_ST_SOC_CFG: begin
        // No limit here: only the host's completion write moves on
        r_next.cnt = 8'h0;
      end
      HBS_ST_CONFIG: begin
        // Host bits override defaults where masked, OTP bits set on top
        if (r_reg.method != HBS_CFG_EEPROM || i_eeprom_done) begin
          r_next.merged = (i_config_default & ~r_reg.cfg_mask) |
                          (r_reg.host_cfg & r_reg.cfg_mask) | i_config_otp;
          r_next.state = HBS_ST_IDLE;
        end
      end
      HBS_ST_IDLE: begin
        // Idle stands in for suspend until VBUS shows up
        if (i_vbus) begin
          r_next.state = r_reg.ctrl[HBS_CTRL_CHG_EN] ? HBS_ST_CHG_DET : HBS_ST_CONNECT;
          r_next.chg_go = r_reg.ctrl[HBS_CTRL_CHG_EN];
        end
      end
      HBS_ST_CHG_DET: begin
        // Clearing the enable mid-detection drops straight to connect
        if (!r_reg.ctrl[HBS_CTRL_CHG_EN] || i_chg_done) begin
          r_next.state = HBS_ST_CONNECT;
        end
      end
      HBS_ST_CONNECT: begin
        if (!r_reg.ctrl[HBS_CTRL_SOFT_DISC]) begin
          r_next.state = HBS_ST_NORMAL;
        end
      end
      HBS_ST_NORMAL: begin
        if (r_reg.ctrl[HBS_CTRL_SOFT_DISC]) begin
          r_next.state = HBS_ST_CONNECT;
        end
      end
      HBS_ST_HALT: begin
        // A bad selection parks here until the next chip reset
        r_next.state = HBS_ST_HALT;
      end
      default: r_next.state = HBS_ST_STANDBY;
    endcase
  end

  // Whole state resets while reset is low: zeros, except state to standby and ctrl to HBS_CTRL_RESET
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r_reg <= '0;
      r_reg.state <= HBS_ST_STANDBY;
      r_reg.ctrl <= HBS_CTRL_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // Output decode
  // Readies are inverted registered flags, so a taken request drops them in the next cycle
  assign o_awready = !r_reg.aw_got;
  assign o_wready = !r_reg.w_got;
  assign o_bvalid = r_reg.bvalid;
  assign o_bresp = r_reg.bresp;
  assign o_arready = !r_reg.rvalid;
  assign o_rvalid = r_reg.rvalid;
  assign o_rdata = r_reg.rdata;
  assign o_rresp = r_reg.rresp;
  assign o_reg12_en = r_reg.state != HBS_ST_STANDBY;
  assign o_pll_en = r_reg.state != HBS_ST_STANDBY;
  assign o_core_rst_b = !(r_reg.state == HBS_ST_STANDBY || r_reg.state == HBS_ST_HARD_INIT);
  assign o_strap_oe_b = r_reg.state == HBS_ST_STANDBY || r_reg.state == HBS_ST_HARD_INIT;
  assign o_bus_probe_oe_b = !r_reg.probe;
  assign o_eeprom_load = r_reg.eep_go;
  assign o_chg_start = r_reg.chg_go;
  assign o_hub_connect = r_reg.state == HBS_ST_CONNECT;
  assign o_normal = r_reg.state == HBS_ST_NORMAL;
  assign o_self_powered = r_reg.method == HBS_CFG_SELF;
  assign o_straps_used = r_reg.method == HBS_CFG_SELF || r_reg.method == HBS_CFG_BUS;
  assign o_smbus_en = smbus_ok;
  assign o_config = r_reg.merged;
  assign o_ec_en = r_reg.ec_en;
  assign o_special_resume = r_reg.sres_en;
  assign o_hub_reset = r_reg.hub_rst;
endmodule
`default_nettype wire

// ===== rtl/hbs_pkg.sv
// Purpose: Shared constants for the hub boot stage sequencer
// Assumes: 10 MHz system clock
// Notes: Byte addresses on the AXI4-Lite slave; the done register sits at four times its index
package hbs_pkg;
  localparam logic [9:0] HBS_ADDR_CTRL = 10'h000;
  localparam logic [9:0] HBS_ADDR_STAT = 10'h004;
  localparam logic [9:0] HBS_ADDR_SUSP = 10'h008;
  localparam logic [9:0] HBS_ADDR_VCMD = 10'h00C;
  // The completion register is known by its index; its byte address is four times that
  localparam logic [7:0] HBS_IDX_DONE = 8'hFF;
  localparam logic [9:0] HBS_ADDR_DONE = {HBS_IDX_DONE, 2'h0};
  localparam logic [1:0] HBS_RESP_OKAY = 2'h0;
  localparam logic [1:0] HBS_RESP_SLVERR = 2'h2;
  // Control register fields
  localparam int HBS_CTRL_CHG_EN = 0;
  localparam int HBS_CTRL_SOFT_DISC = 1;
  localparam int HBS_CTRL_VCMD_EN = 2;
  localparam logic [2:0] HBS_CTRL_RESET = 3'h5;
  // Vendor command codes
  localparam logic [2:0] HBS_VCMD_EC_ON = 3'h1;
  localparam logic [2:0] HBS_VCMD_EC_OFF = 3'h2;
  localparam logic [2:0] HBS_VCMD_SR_ON = 3'h3;
  localparam logic [2:0] HBS_VCMD_SR_OFF = 3'h4;
  localparam logic [2:0] HBS_VCMD_RESET = 3'h5;
  // Configuration methods
  localparam logic [2:0] HBS_CFG_SELF = 3'h0;
  localparam logic [2:0] HBS_CFG_BUS = 3'h1;
  localparam logic [2:0] HBS_CFG_EEPROM = 3'h2;
  localparam logic [2:0] HBS_CFG_SMBUS = 3'h3;
  localparam logic [2:0] HBS_CFG_INVALID = 3'h4;
  // Hardware init settle time
  localparam int HBS_HARD_INIT_NS = 1000;
  localparam int HBS_CLK_NS = 100;
  localparam logic [7:0] HBS_HARD_INIT_CYC =
    8'((HBS_HARD_INIT_NS + HBS_CLK_NS - 1) / HBS_CLK_NS);
  typedef enum logic [9:0] {
    HBS_ST_STANDBY = 10'h001,
    HBS_ST_HARD_INIT = 10'h002,
    HBS_ST_FW_INIT = 10'h004,
    HBS_ST_SOC_CFG = 10'h008,
    HBS_ST_CONFIG = 10'h010,
    HBS_ST_IDLE = 10'h020,
    HBS_ST_CHG_DET = 10'h040,
    HBS_ST_CONNECT = 10'h080,
    HBS_ST_NORMAL = 10'h100,
    HBS_ST_HALT = 10'h200
  } hbs_state_t;
endpackage

// ===== tb/hbs_seq_chk.sv
// Purpose: Port assertions for the hub boot stage sequencer
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound to every sequencer instance
`timescale 1ns/1ns
`default_nettype none
module hbs_seq_chk (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic i_reference_clock_in,
  input wire logic o_reg12_en,
  input wire logic o_pll_en,
  input wire logic o_smbus_en,
  input wire logic o_strap_oe_b,
  input wire logic o_hub_connect,
  input wire logic o_normal,
  input wire logic o_chg_start,
  input wire logic i_vbus
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // Standby keeps supplies, clock and bus down
  AST_STANDBY: assert property (!o_reg12_en |-> !o_pll_en && !o_smbus_en && !o_normal)
    else $error("power up in standby");
  AST_STRAP_HIZ: assert property (!o_reg12_en |-> o_strap_oe_b)
    else $error("straps driven in standby");
  // Logic not yet stable, so the bus must stay deaf
  AST_HW_NOBUS: assert property (o_strap_oe_b |-> !o_smbus_en)
    else $error("bus live in hardware_init_stage");
  AST_HW_LEN: assert property ($rose(o_reg12_en) |-> o_strap_oe_b [*8])
    else $error("hardware_init_stage too short");
  AST_REF_CLOCK: assert property ($fell(o_strap_oe_b) |-> $past(i_reference_clock_in))
    else $error("left hardware_init_stage without clock");
  AST_CHG_PULSE: assert property (o_chg_start |=> !o_chg_start)
    else $error("charger start not a pulse");
  // Charger detection is only launched from idle with VBUS seen
  AST_CHG_VBUS: assert property (o_chg_start |-> $past(i_vbus))
    else $error("charger start without vbus");
  AST_NORMAL: assert property (o_normal |-> !o_hub_connect && o_reg12_en)
    else $error("normal with connect");
  AST_RD: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read not answered");
endmodule
bind hbs_sequencer hbs_seq_chk u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .o_rvalid(o_rvalid), .i_reference_clock_in(i_reference_clock_in),
  .o_reg12_en(o_reg12_en), .o_pll_en(o_pll_en), .o_smbus_en(o_smbus_en),
  .o_strap_oe_b(o_strap_oe_b), .o_hub_connect(o_hub_connect), .o_normal(o_normal),
  .o_chg_start(o_chg_start), .i_vbus(i_vbus));
`default_nettype wire

// ===== tb/hbs_far_model.sv
// Purpose: Far side: configuration memory and host bus pull-ups
// Assumes: Probe pull-downs active while i_probe_oe_b is low
// Notes: Load time is a plain parameter
`timescale 1ns/1ns
`default_nettype none
module hbs_far_model #(
  parameter int LOAD_CYC = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_probe_oe_b,
  input wire logic i_eeprom_load,
  input wire logic i_bus_present,
  input wire logic i_sda_strap,
  output logic o_sda,
  output logic o_scl,
  output logic o_eeprom_done
);
  int cnt;
  // Host pull-ups beat the weak probe pull-downs; with no host the lines sink low
  assign o_sda = i_probe_oe_b ? i_sda_strap : i_bus_present;
  assign o_scl = i_probe_oe_b ? 1'h1 : i_bus_present;
  // Memory finishes some cycles after the request; done stands until reset or the next load request
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) cnt <= 0;
    else if (i_eeprom_load) cnt <= 1;
    else if (cnt != 0 && cnt < LOAD_CYC) cnt <= cnt + 1;
  end
  assign o_eeprom_done = (cnt == LOAD_CYC);
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Purpose: Register-level test of the hub boot stage sequencer
// Assumes: AXI4-Lite master tasks, 10 MHz clock
// Notes: Straps and far-side bus chosen per boot
`timescale 1ns/1ns
`default_nettype none
module tb;
  import hbs_pkg::*;
  logic i_clk = 1'h0, i_rst_b = 1'h0, i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0;
  logic i_arvalid = 1'h0, i_rready = 1'h0, i_reference_clock_in = 1'h0, i_vbus = 1'h0;
  logic i_usb_suspend = 1'h0, sda_s = 1'h0, bus_p = 1'h0;
  logic [9:0] i_awaddr = 10'h000, i_araddr = 10'h000;
  logic [3:0] i_wstrb = 4'hF;
  logic [31:0] i_wdata = 32'h0, d, o_rdata;
  logic [1:0] i_cfg_sel = 2'h0, r, o_bresp, o_rresp;
  logic [2:0] o_config;
  logic [1:0] ve [4] = '{2'h1, 2'h0, 2'h2, 2'h0};
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_bus_probe_oe_b, o_strap_oe_b;
  logic o_eeprom_load, o_chg_start, o_hub_connect, o_normal, o_self_powered, o_straps_used;
  logic o_hub_reset, i_sda_in, i_scl_in, i_eeprom_done;
  logic o_reg12_en, o_pll_en, o_core_rst_b, o_smbus_en, o_ec_en, o_special_resume, chg_dn = 1'h0;
  int miscompares = 0, num_checks = 0, n_chg = 0, n_hrst = 0;
  hbs_sequencer uut (.i_clk, .i_rst_b, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
    .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
    .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_reference_clock_in,
    .i_pll_locked(1'h1), .i_cfg_sel, .i_sda_in, .i_scl_in, .i_vbus, .i_usb_suspend,
    .i_eeprom_done, .i_chg_done(chg_dn), .i_config_default(3'h5), .i_config_otp(3'h2),
    .o_bus_probe_oe_b, .o_strap_oe_b, .o_reg12_en, .o_pll_en, .o_core_rst_b,
    .o_eeprom_load, .o_chg_start, .o_hub_connect, .o_normal, .o_self_powered,
    .o_straps_used, .o_smbus_en, .o_config, .o_ec_en, .o_special_resume, .o_hub_reset);
  hbs_far_model far (.i_clk, .i_rst_b, .i_probe_oe_b(o_bus_probe_oe_b),
    .i_eeprom_load(o_eeprom_load), .i_bus_present(bus_p), .i_sda_strap(sda_s),
    .o_sda(i_sda_in), .o_scl(i_scl_in), .o_eeprom_done(i_eeprom_done));
  always #50 i_clk = ~i_clk;
  // Pulse counters; pulses last one cycle so each edge counts once
  always @(posedge i_clk) begin
    if (o_chg_start) n_chg++;
    if (o_hub_reset) n_hrst++;
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Ready is looked at on the falling edge, so the handshake edge is the next rising one
  task automatic wr(input logic [9:0] a, input logic [31:0] v);
    logic ta, tw;
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= v;
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    i_bready <= 1'h1;
    do begin
      @(negedge i_clk);
      ta = i_awvalid & o_awready;
      tw = i_wvalid & o_wready;
      @(posedge i_clk);
      if (ta) i_awvalid <= 1'h0;
      if (tw) i_wvalid <= 1'h0;
    end while ((i_awvalid && !ta) || (i_wvalid && !tw));
    do @(negedge i_clk); while (!o_bvalid);
    r = o_bresp;
    @(posedge i_clk);
    i_bready <= 1'h0;
  endtask
  task automatic rd(input logic [9:0] a);
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'h1;
    i_rready <= 1'h1;
    do @(negedge i_clk); while (!o_arready);
    @(posedge i_clk);
    i_arvalid <= 1'h0;
    do @(negedge i_clk); while (!o_rvalid);
    d = o_rdata;
    r = o_rresp;
    @(posedge i_clk);
    i_rready <= 1'h0;
  endtask
  task automatic st(input logic [9:0] e);
    rd(HBS_ADDR_STAT);
    chk("state", d[9:0], e);
  endtask
  task automatic boot(input logic [1:0] s, input logic sd, bp, ck);
    @(posedge i_clk);
    i_rst_b <= 1'h0;
    i_cfg_sel <= s;
    sda_s <= sd;
    bus_p <= bp;
    i_reference_clock_in <= ck;
    i_vbus <= 1'h0;
    i_usb_suspend <= 1'h0;
    repeat (10) @(posedge i_clk);
    chk("standby", {o_reg12_en, o_pll_en, o_smbus_en}, 3'h0);
    i_rst_b <= 1'h1;
    rd(HBS_ADDR_CTRL);
    chk("early resp", r, HBS_RESP_SLVERR);
    repeat (60) @(posedge i_clk);
  endtask
  // Hang guard, far beyond the under one thousand cycles the tests take
  initial begin
    repeat (8000) @(posedge i_clk);
    miscompares++;
    close_out;
  end
  initial begin
    boot(2'h0, 1'h1, 1'h0, 1'h0);
    chk("no clock", o_strap_oe_b, 1'h1);
    chk("core held", {o_core_rst_b, o_reg12_en, o_pll_en}, 3'h3);
    i_reference_clock_in <= 1'h1;
    repeat (60) @(posedge i_clk);
    st(HBS_ST_IDLE);
    chk("method", d[12:10], HBS_CFG_SELF);
    chk("self", o_self_powered, 1'h1);
    chk("core up", o_core_rst_b, 1'h1);
    rd(HBS_ADDR_CTRL);
    chk("ctrl", d[2:0], HBS_CTRL_RESET);
    i_wstrb <= 4'hE;
    wr(HBS_ADDR_CTRL, 32'h0);
    i_wstrb <= 4'hF;
    rd(HBS_ADDR_CTRL);
    chk("lane0 off", d[2:0], HBS_CTRL_RESET);
    i_vbus <= 1'h1;
    repeat (20) @(posedge i_clk);
    st(HBS_ST_CHG_DET);
    chk("chg", n_chg, 32'h1);
    chg_dn <= 1'h1;
    repeat (20) @(posedge i_clk);
    st(HBS_ST_NORMAL);
    wr(HBS_ADDR_CTRL, 32'h7);
    repeat (5) @(posedge i_clk);
    chk("disc", o_hub_connect, 1'h1);
    wr(HBS_ADDR_CTRL, 32'h5);
    repeat (5) @(posedge i_clk);
    chk("recon", o_normal, 1'h1);
    for (int i = 0; i < 4; i++) begin
      wr(HBS_ADDR_VCMD, 32'(i + 1));
      rd(HBS_ADDR_VCMD);
      chk("vcmd", d[1:0], ve[i]);
      chk("vcmd pins", {o_special_resume, o_ec_en}, ve[i]);
    end
    wr(HBS_ADDR_VCMD, 32'(HBS_VCMD_RESET));
    repeat (3) @(posedge i_clk);
    chk("hub rst", n_hrst, 32'h1);
    wr(10'h040, 32'h0);
    chk("unmapped", r, HBS_RESP_SLVERR);
    $display("test 1 done");
    boot(2'h2, 1'h0, 1'h0, 1'h1);
    chk("bus pwr", o_self_powered, 1'h0);
    wr(HBS_ADDR_CTRL, 32'h4);
    i_vbus <= 1'h1;
    repeat (20) @(posedge i_clk);
    st(HBS_ST_NORMAL);
    chk("no chg", n_chg, 32'h1);
    $display("test 2 done");
    boot(2'h3, 1'h1, 1'h0, 1'h1);
    st(HBS_ST_IDLE);
    chk("eeprom", d[12:10], HBS_CFG_EEPROM);
    chk("straps", o_straps_used, 1'h0);
    $display("test 3 done");
    boot(2'h1, 1'h1, 1'h1, 1'h1);
    st(HBS_ST_SOC_CFG);
    repeat (200) @(posedge i_clk);
    st(HBS_ST_SOC_CFG);
    wr(HBS_ADDR_DONE, 32'h100);
    repeat (10) @(posedge i_clk);
    chk("merge", o_config, 3'h6);
    wr(HBS_ADDR_SUSP, 32'h1);
    i_usb_suspend <= 1'h1;
    rd(HBS_ADDR_CTRL);
    chk("awake", r, HBS_RESP_OKAY);
    chk("awake pin", o_smbus_en, 1'h1);
    wr(HBS_ADDR_SUSP, 32'h0);
    rd(HBS_ADDR_CTRL);
    chk("asleep", r, HBS_RESP_SLVERR);
    chk("asleep pin", o_smbus_en, 1'h0);
    $display("test 4 done");
    boot(2'h1, 1'h0, 1'h0, 1'h1);
    st(HBS_ST_HALT);
    $display("test 5 done");
    close_out;
  end
endmodule
`default_nettype wire
